// ---- core/grf_top.sv ----
//
// Overview of operation
// - range code 00/01/11 gives 245/500/2000 dps
// - rate code selects power-down or data rate
// - rate field is common rate with accelerometer while accelerometer is active and gyro is not powered down
// - bandwidth plus rate sets second low-pass cutoff
// - first low-pass cutoff follows data rate only
// - interrupt path field picks interrupt signal version
// - output path field picks output signal version
// - low-power bit selects gyro low-power operation
// - high-pass enable bit inserts high-pass filter
// - four-bit code sets high-pass cutoff by rate
// - sign bits invert axes; orientation remaps axes
//
`default_nettype none
module grf_top
	import grf_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	// apb slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [APB_AW-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// sensor core status
	input wire logic ACCEL_ACTIVE_I,
	// rate settings
	output logic GYRO_POWER_DOWN_O,
	output logic [2:0] GYRO_RATE_SEL_O,
	output logic [15:0] GYRO_RATE_DHZ_O,
	output logic [2:0] COMMON_RATE_SEL_O,
	output logic COMMON_RATE_VALID_O,
	output logic [1:0] GYRO_RANGE_SEL_O,
	output logic [11:0] GYRO_RANGE_DPS_O,
	// filter chain settings
	output logic [1:0] GYRO_BW_SEL_O,
	output logic [7:0] FIRST_LOWPASS_HZ_O,
	output logic [7:0] SECOND_LOWPASS_HZ_O,
	output logic SECOND_LOWPASS_ON_O,
	output logic GYRO_LOW_POWER_O,
	output logic HIGHPASS_ON_O,
	output logic [3:0] HIGHPASS_CUTOFF_SEL_O,
	output logic [15:0] HIGHPASS_CUTOFF_MHZ_O,
	output logic [1:0] INT_PATH_SEL_O,
	output logic [1:0] OUT_PATH_SEL_O,
	// rate samples in
	input wire logic SAMPLE_VALID_I,
	input wire logic [15:0] PITCH_RATE_I,
	input wire logic [15:0] ROLL_RATE_I,
	input wire logic [15:0] YAW_RATE_I,
	// rate samples out
	output logic SAMPLE_VALID_O,
	output logic [15:0] PITCH_RATE_O,
	output logic [15:0] ROLL_RATE_O,
	output logic [15:0] YAW_RATE_O
);

	// --------------------------------------------------------------
	// functions
	// --------------------------------------------------------------
	// picks input axis 0..2 (pitch, roll, yaw)
	function automatic logic [15:0] axis_pick(input logic [1:0] sel,
		input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
		logic [15:0] r;
		case (sel)
			2'd1: r = y;
			2'd2: r = z;
			default: r = x;
		endcase
		return r;
	endfunction

	// saturating negate keeps full-scale negative from wrapping
	function automatic logic [15:0] neg_sat(input logic [15:0] v, input logic inv);
		logic [15:0] r;
		r = v;
		if (inv) begin
			r = (v == SAMPLE_MIN) ? SAMPLE_MAX : 16'(~v + 16'h0001);
		end
		return r;
	endfunction

	function automatic logic is_mapped(input logic [9:0] idx);
		return idx == IDX_RATE_RANGE || idx == IDX_PATH_SELECT || idx == IDX_FILTER ||
			idx == IDX_AXIS_SIGN_MAP || idx == IDX_STATUS;
	endfunction

	// --------------------------------------------------------------
	// apb decode
	// --------------------------------------------------------------
	logic [9:0] word_idx;
	logic aligned, hit, setup_phase, wr_take;

	assign word_idx = PADDR_I[APB_AW-1:2];
	assign aligned = PADDR_I[1:0] == 2'b00;
	assign hit = aligned && is_mapped(word_idx);
	assign setup_phase = PSEL_I && !PENABLE_I;
	// a write lands once, at the access edge; only byte lane 0 carries data
	assign wr_take = PSEL_I && PENABLE_I && PWRITE_I && hit && PSTRB_I[0];

	// --------------------------------------------------------------
	// control registers
	// --------------------------------------------------------------
	logic [7:0] rate_range_q, rate_range_d;
	logic [7:0] path_q, path_d;
	logic [7:0] filter_q, filter_d;
	logic [7:0] orient_q, orient_d;
	logic [7:0] wbyte;
	logic [2:0] new_rate;
	logic [1:0] new_range;

	always_comb begin
		rate_range_d = rate_range_q;
		path_d = path_q;
		filter_d = filter_q;
		orient_d = orient_q;
		wbyte = PWDATA_I[7:0];
		new_rate = wbyte[RATE_LSB +: 3];
		new_range = wbyte[RANGE_LSB +: 2];
		if (wr_take) begin
			case (word_idx)
				IDX_RATE_RANGE: begin
					// reserved bits stay zero whatever the host writes
					rate_range_d = wbyte & MASK_RATE_RANGE;
					if (new_rate == RATE_UNAVAIL) begin
						rate_range_d[RATE_LSB +: 3] = rate_range_q[RATE_LSB +: 3];
					end
					if (new_range == RANGE_UNAVAIL) begin
						rate_range_d[RANGE_LSB +: 2] = rate_range_q[RANGE_LSB +: 2];
					end
				end
				IDX_PATH_SELECT: begin
					path_d = wbyte & MASK_PATH_SELECT;
				end
				IDX_FILTER: begin
					filter_d = wbyte & MASK_FILTER;
				end
				IDX_AXIS_SIGN_MAP: begin
					orient_d = wbyte & MASK_AXIS_SIGN_MAP;
				end
				default: begin
					orient_d = orient_q;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rate_range_q <= RST_RATE_RANGE;
			path_q <= RST_PATH_SELECT;
			filter_q <= RST_FILTER;
			orient_q <= RST_AXIS_SIGN_MAP;
		end else begin
			rate_range_q <= rate_range_d;
			path_q <= path_d;
			filter_q <= filter_d;
			orient_q <= orient_d;
		end
	end

	// --------------------------------------------------------------
	// field decode
	// --------------------------------------------------------------
	logic [2:0] rate_sel;
	logic [1:0] range_sel, bw_sel;
	logic [3:0] hpcf_sel;
	logic power_down;
	logic [7:0] lp1_hz, lp2_hz;
	logic lp2_on;
	logic [15:0] hp_mhz;

	assign rate_sel = rate_range_q[RATE_LSB +: 3];
	assign range_sel = rate_range_q[RANGE_LSB +: 2];
	assign bw_sel = rate_range_q[BW_LSB +: 2];
	assign hpcf_sel = filter_q[HPCF_LSB +: 4];
	assign power_down = rate_sel == RATE_POWER_DOWN;

	grf_filter_lut u_lut (
		.clk_i(CLK_I),
		.reset_n_i(RESET_N_I),
		.rate_i(rate_sel),
		.bw_i(bw_sel),
		.hpcf_i(hpcf_sel),
		.lp1_hz_o(lp1_hz),
		.lp2_hz_o(lp2_hz),
		.lp2_on_o(lp2_on),
		.hp_mhz_o(hp_mhz)
	);

	// --------------------------------------------------------------
	// setting outputs
	// --------------------------------------------------------------
	logic common_valid;

	// both sensors share the gyro rate only while the gyro runs
	assign common_valid = ACCEL_ACTIVE_I && !power_down;

	assign GYRO_POWER_DOWN_O = power_down;
	assign GYRO_RATE_SEL_O = rate_sel;
	assign GYRO_RATE_DHZ_O = RATE_DHZ[rate_sel];
	assign COMMON_RATE_SEL_O = common_valid ? rate_sel : RATE_POWER_DOWN;
	assign COMMON_RATE_VALID_O = common_valid;
	assign GYRO_RANGE_SEL_O = range_sel;
	assign GYRO_RANGE_DPS_O = RANGE_DPS[range_sel];
	assign GYRO_BW_SEL_O = bw_sel;
	assign FIRST_LOWPASS_HZ_O = lp1_hz;
	assign SECOND_LOWPASS_HZ_O = lp2_hz;
	assign SECOND_LOWPASS_ON_O = lp2_on;
	assign GYRO_LOW_POWER_O = filter_q[LOW_POWER_BIT];
	assign HIGHPASS_ON_O = filter_q[HIGHPASS_BIT];
	assign HIGHPASS_CUTOFF_SEL_O = hpcf_sel;
	assign HIGHPASS_CUTOFF_MHZ_O = hp_mhz;
	assign INT_PATH_SEL_O = path_q[INT_PATH_LSB +: 2];
	assign OUT_PATH_SEL_O = path_q[OUT_PATH_LSB +: 2];

	// --------------------------------------------------------------
	// axis remap and sign
	// --------------------------------------------------------------
	logic [1:0] src_p, src_r, src_y;
	logic [15:0] pitch_d, roll_d, yaw_d, pitch_q, roll_q, yaw_q;
	logic valid_d, valid_q;

	always_comb begin
		case (orient_q[ORIENT_LSB +: 3])
			ORIENT_XZY: {src_p, src_r, src_y} = {2'd0, 2'd2, 2'd1};
			ORIENT_YXZ: {src_p, src_r, src_y} = {2'd1, 2'd0, 2'd2};
			ORIENT_YZX: {src_p, src_r, src_y} = {2'd1, 2'd2, 2'd0};
			ORIENT_ZXY: {src_p, src_r, src_y} = {2'd2, 2'd0, 2'd1};
			ORIENT_ZYX: {src_p, src_r, src_y} = {2'd2, 2'd1, 2'd0};
			default: {src_p, src_r, src_y} = {2'd0, 2'd1, 2'd2};
		endcase
		// samples arriving in power-down are dropped
		valid_d = SAMPLE_VALID_I && !power_down;
		pitch_d = pitch_q;
		roll_d = roll_q;
		yaw_d = yaw_q;
		if (valid_d) begin
			pitch_d = neg_sat(axis_pick(src_p, PITCH_RATE_I, ROLL_RATE_I, YAW_RATE_I),
				orient_q[PITCH_SIGN_BIT]);
			roll_d = neg_sat(axis_pick(src_r, PITCH_RATE_I, ROLL_RATE_I, YAW_RATE_I),
				orient_q[ROLL_SIGN_BIT]);
			yaw_d = neg_sat(axis_pick(src_y, PITCH_RATE_I, ROLL_RATE_I, YAW_RATE_I),
				orient_q[YAW_SIGN_BIT]);
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			pitch_q <= 16'h0000;
			roll_q <= 16'h0000;
			yaw_q <= 16'h0000;
			valid_q <= 1'b0;
		end else begin
			pitch_q <= pitch_d;
			roll_q <= roll_d;
			yaw_q <= yaw_d;
			valid_q <= valid_d;
		end
	end

	assign SAMPLE_VALID_O = valid_q;
	assign PITCH_RATE_O = pitch_q;
	assign ROLL_RATE_O = roll_q;
	assign YAW_RATE_O = yaw_q;

	// --------------------------------------------------------------
	// apb read and error
	// --------------------------------------------------------------
	logic [31:0] rdata_d, rdata_q;
	logic slverr_d, slverr_q;
	logic [7:0] status_byte;

	always_comb begin
		status_byte = 8'h00;
		status_byte[ST_POWER_DOWN_BIT] = power_down;
		status_byte[ST_COMMON_BIT] = common_valid;
		status_byte[ST_ACCEL_BIT] = ACCEL_ACTIVE_I;
		status_byte[ST_LP2_BIT] = lp2_on;
		status_byte[ST_HPCF_BAD_BIT] = hpcf_sel > HPCF_MAX;
		rdata_d = rdata_q;
		slverr_d = slverr_q;
		// read data and error are captured in the setup cycle so both come from flops
		if (setup_phase) begin
			slverr_d = !hit;
			rdata_d = 32'h0000_0000;
			if (!PWRITE_I && hit) begin
				case (word_idx)
					IDX_RATE_RANGE: rdata_d[7:0] = rate_range_q;
					IDX_PATH_SELECT: rdata_d[7:0] = path_q;
					IDX_FILTER: rdata_d[7:0] = filter_q;
					IDX_AXIS_SIGN_MAP: rdata_d[7:0] = orient_q;
					default: rdata_d[7:0] = status_byte;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rdata_q <= 32'h0000_0000;
			slverr_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			slverr_q <= slverr_d;
		end
	end

	assign PREADY_O = 1'b1;
	assign PRDATA_O = rdata_q;
	assign PSLVERR_O = slverr_q && PSEL_I && PENABLE_I;

endmodule
`default_nettype wire

// ---- core/grf_pkg.sv ----
`default_nettype none
package grf_pkg;

	// --------------------------------------------------------------
	// bus and register map (word index, byte address = 4 * index)
	// --------------------------------------------------------------
	localparam int APB_AW = 12;
	localparam logic [9:0] IDX_RATE_RANGE = 10'h010;
	localparam logic [9:0] IDX_PATH_SELECT = 10'h011;
	localparam logic [9:0] IDX_FILTER = 10'h012;
	localparam logic [9:0] IDX_AXIS_SIGN_MAP = 10'h013;
	localparam logic [9:0] IDX_STATUS = 10'h030;

	// --------------------------------------------------------------
	// reset values and writable masks
	// --------------------------------------------------------------
	localparam logic [7:0] RST_RATE_RANGE = 8'h00;
	localparam logic [7:0] RST_PATH_SELECT = 8'h00;
	localparam logic [7:0] RST_FILTER = 8'h00;
	localparam logic [7:0] RST_AXIS_SIGN_MAP = 8'h00;
	localparam logic [7:0] MASK_RATE_RANGE = 8'hFB;
	localparam logic [7:0] MASK_PATH_SELECT = 8'h0F;
	localparam logic [7:0] MASK_FILTER = 8'hCF;
	localparam logic [7:0] MASK_AXIS_SIGN_MAP = 8'h3F;

	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int RATE_LSB = 5;
	localparam int RANGE_LSB = 3;
	localparam int BW_LSB = 0;
	localparam int INT_PATH_LSB = 2;
	localparam int OUT_PATH_LSB = 0;
	localparam int LOW_POWER_BIT = 7;
	localparam int HIGHPASS_BIT = 6;
	localparam int HPCF_LSB = 0;
	localparam int PITCH_SIGN_BIT = 5;
	localparam int ROLL_SIGN_BIT = 4;
	localparam int YAW_SIGN_BIT = 3;
	localparam int ORIENT_LSB = 0;
	localparam int ST_POWER_DOWN_BIT = 0;
	localparam int ST_COMMON_BIT = 1;
	localparam int ST_ACCEL_BIT = 2;
	localparam int ST_LP2_BIT = 3;
	localparam int ST_HPCF_BAD_BIT = 4;

	// --------------------------------------------------------------
	// codes
	// --------------------------------------------------------------
	localparam logic [1:0] RANGE_UNAVAIL = 2'b10;
	localparam logic [2:0] RATE_POWER_DOWN = 3'b000;
	localparam logic [2:0] RATE_14HZ = 3'b001;
	localparam logic [2:0] RATE_59HZ = 3'b010;
	localparam logic [2:0] RATE_119HZ = 3'b011;
	localparam logic [2:0] RATE_UNAVAIL = 3'b111;
	localparam logic [3:0] HPCF_MAX = 4'h9;
	localparam logic [2:0] ORIENT_XZY = 3'b001;
	localparam logic [2:0] ORIENT_YXZ = 3'b010;
	localparam logic [2:0] ORIENT_YZX = 3'b011;
	localparam logic [2:0] ORIENT_ZXY = 3'b100;
	localparam logic [2:0] ORIENT_ZYX = 3'b101;
	localparam logic [15:0] SAMPLE_MIN = 16'h8000;
	localparam logic [15:0] SAMPLE_MAX = 16'h7FFF;

	// --------------------------------------------------------------
	// lookup tables
	// --------------------------------------------------------------
	// output data rate in tenths of Hz, by rate code
	localparam logic [15:0] RATE_DHZ [8] = '{16'h0000, 16'h0095, 16'h0253, 16'h04A6,
		16'h094C, 16'h1298, 16'h2530, 16'h0000};
	// full scale in dps, by range code
	localparam logic [11:0] RANGE_DPS [4] = '{12'h0F5, 12'h1F4, 12'h000, 12'h7D0};
	// first low-pass cutoff in Hz, by rate code
	localparam logic [7:0] LP1_HZ [8] = '{8'h00, 8'h05, 8'h13, 8'h26,
		8'h4C, 8'h64, 8'h64, 8'h00};
	localparam logic [7:0] LP2_HZ_59 = 8'h10;
	// second low-pass cutoff in Hz, index {rate - 119 Hz code, bandwidth}
	localparam logic [7:0] LP2_HZ [16] = '{8'h0E, 8'h1F, 8'h1F, 8'h1F,
		8'h0E, 8'h1D, 8'h3F, 8'h4E, 8'h15, 8'h1C, 8'h39, 8'h64,
		8'h21, 8'h28, 8'h3A, 8'h64};
	// high-pass cutoff ladder in mHz; slower rates start further down it
	localparam logic [15:0] HP_LADDER_MHZ [16] = '{16'hDEA8, 16'h7530, 16'h3A98, 16'h1F40,
		16'h0FA0, 16'h07D0, 16'h03E8, 16'h01F4, 16'h00C8, 16'h0064, 16'h0032, 16'h0014,
		16'h000A, 16'h0005, 16'h0002, 16'h0001};
	localparam logic [3:0] HP_SHIFT [8] = '{4'h0, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0, 4'h0};

endpackage
`default_nettype wire

// ---- core/grf_filter_lut.sv ----
`default_nettype none
module grf_filter_lut
	import grf_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// settings
	input wire logic [2:0] rate_i,
	input wire logic [1:0] bw_i,
	input wire logic [3:0] hpcf_i,
	// registered cutoffs
	output logic [7:0] lp1_hz_o,
	output logic [7:0] lp2_hz_o,
	output logic lp2_on_o,
	output logic [15:0] hp_mhz_o
);

	// --------------------------------------------------------------
	// table decode
	// --------------------------------------------------------------
	logic [7:0] lp1_d, lp1_q, lp2_d, lp2_q;
	logic lp2_on_d, lp2_on_q;
	logic [15:0] hp_d, hp_q;
	logic [2:0] lp2_row;
	logic [3:0] hp_idx;

	always_comb begin
		lp2_row = rate_i - RATE_119HZ;
		hp_idx = hpcf_i + HP_SHIFT[rate_i];
		lp1_d = LP1_HZ[rate_i];
		lp2_d = 8'h00;
		lp2_on_d = 1'b0;
		hp_d = 16'h0000;
		if (hpcf_i <= HPCF_MAX && rate_i != RATE_POWER_DOWN && rate_i != RATE_UNAVAIL) begin
			hp_d = HP_LADDER_MHZ[hp_idx];
		end
		case (rate_i)
			RATE_POWER_DOWN, RATE_14HZ, RATE_UNAVAIL: begin
				lp2_on_d = 1'b0;
			end
			RATE_59HZ: begin
				lp2_on_d = 1'b1;
				lp2_d = LP2_HZ_59;
			end
			default: begin
				lp2_on_d = 1'b1;
				lp2_d = LP2_HZ[{lp2_row[1:0], bw_i}];
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lp1_q <= 8'h00;
			lp2_q <= 8'h00;
			lp2_on_q <= 1'b0;
			hp_q <= 16'h0000;
		end else begin
			lp1_q <= lp1_d;
			lp2_q <= lp2_d;
			lp2_on_q <= lp2_on_d;
			hp_q <= hp_d;
		end
	end

	assign lp1_hz_o = lp1_q;
	assign lp2_hz_o = lp2_q;
	assign lp2_on_o = lp2_on_q;
	assign hp_mhz_o = hp_q;

endmodule
`default_nettype wire

// ---- core/grf_top_end.sv ----
`default_nettype none
`default_nettype wire

// ---- tb/grf_top_properties.sv ----
`default_nettype none
module grf_top_properties
	import grf_pkg::*;
(
	// clock, reset and bus
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic [APB_AW-1:0] PADDR_I,
	input wire logic PSLVERR_O,
	// settings and samples
	input wire logic ACCEL_ACTIVE_I,
	input wire logic GYRO_POWER_DOWN_O,
	input wire logic [2:0] GYRO_RATE_SEL_O,
	input wire logic COMMON_RATE_VALID_O,
	input wire logic [1:0] GYRO_RANGE_SEL_O,
	input wire logic [11:0] GYRO_RANGE_DPS_O,
	input wire logic [7:0] FIRST_LOWPASS_HZ_O,
	input wire logic [7:0] SECOND_LOWPASS_HZ_O,
	input wire logic SECOND_LOWPASS_ON_O,
	input wire logic [3:0] HIGHPASS_CUTOFF_SEL_O,
	input wire logic [15:0] HIGHPASS_CUTOFF_MHZ_O,
	input wire logic SAMPLE_VALID_I,
	input wire logic SAMPLE_VALID_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	AST_POWER_DOWN: assert property (GYRO_POWER_DOWN_O == (GYRO_RATE_SEL_O == 3'b000))
		else $error("power-down flag disagrees with rate code");
	AST_RANGE_KEPT: assert property (GYRO_RANGE_SEL_O != 2'b10)
		else $error("unavailable range code stored");
	AST_RANGE_DPS: assert property (GYRO_RANGE_SEL_O == 2'b11
		|-> GYRO_RANGE_DPS_O == 12'h7D0)
		else $error("range code 11 not decoded as 2000");
	AST_COMMON: assert property (COMMON_RATE_VALID_O ==
		(ACCEL_ACTIVE_I && !GYRO_POWER_DOWN_O))
		else $error("common rate valid wrong");
	AST_LP1: assert property (GYRO_RATE_SEL_O == 3'b001 |=> FIRST_LOWPASS_HZ_O == 8'h05)
		else $error("first lowpass wrong at lowest rate");
	AST_LP2_59: assert property (GYRO_RATE_SEL_O == 3'b010
		|=> SECOND_LOWPASS_ON_O && SECOND_LOWPASS_HZ_O == 8'h10)
		else $error("second lowpass not 16 at second rate");
	AST_LP2_OFF: assert property (GYRO_RATE_SEL_O == 3'b001 |=> !SECOND_LOWPASS_ON_O)
		else $error("second lowpass on at lowest rate");
	AST_HP_TOP: assert property (GYRO_RATE_SEL_O == 3'b110 && HIGHPASS_CUTOFF_SEL_O == 4'h0
		|=> HIGHPASS_CUTOFF_MHZ_O == 16'hDEA8)
		else $error("highpass cutoff not 57 Hz");
	AST_DROP: assert property (SAMPLE_VALID_I && GYRO_POWER_DOWN_O |=> !SAMPLE_VALID_O)
		else $error("sample passed in power-down");
	// back-to-back samples are legal, so the pulse is judged one edge at a time
	AST_PASS: assert property (SAMPLE_VALID_I && !GYRO_POWER_DOWN_O |=> SAMPLE_VALID_O)
		else $error("sample pulse missing");
	AST_IDLE: assert property (!SAMPLE_VALID_I |=> !SAMPLE_VALID_O)
		else $error("sample pulse without input sample");
	AST_ERR: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I)
		else $error("error outside access phase");
	AST_UNALIGNED: assert property (PSEL_I && PENABLE_I && PADDR_I[1:0] != 2'b00 |-> PSLVERR_O)
		else $error("unaligned access not flagged");
	COV_SAMPLE: cover property (SAMPLE_VALID_O);
	COV_ERR: cover property (PSLVERR_O);
	COV_COMMON: cover property (COMMON_RATE_VALID_O);
endmodule
bind grf_top grf_top_properties chk_u (.CLK_I, .RESET_N_I, .PSEL_I, .PENABLE_I, .PADDR_I,
	.PSLVERR_O,
	.ACCEL_ACTIVE_I, .GYRO_POWER_DOWN_O, .GYRO_RATE_SEL_O, .COMMON_RATE_VALID_O,
	.GYRO_RANGE_SEL_O, .GYRO_RANGE_DPS_O, .FIRST_LOWPASS_HZ_O, .SECOND_LOWPASS_HZ_O,
	.SECOND_LOWPASS_ON_O, .HIGHPASS_CUTOFF_SEL_O, .HIGHPASS_CUTOFF_MHZ_O,
	.SAMPLE_VALID_I, .SAMPLE_VALID_O);
`default_nettype wire

// ---- tb/gyro_rate_filter_config_tb.sv ----
`default_nettype none
module gyro_rate_filter_config_tb
	import grf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [11:0] A_RR = {IDX_RATE_RANGE, 2'b00};
	localparam logic [11:0] A_PS = {IDX_PATH_SELECT, 2'b00};
	localparam logic [11:0] A_FI = {IDX_FILTER, 2'b00};
	localparam logic [11:0] A_SM = {IDX_AXIS_SIGN_MAP, 2'b00};
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, accel = 0, sv = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd_v;
	logic pready, pslverr, err_v, pd, cvalid, lp2on, lowp, hpon, svo;
	logic [2:0] rate, crate;
	logic [1:0] range, bw, ipath, opath;
	logic [15:0] dhz, hpmhz, pi = '0, ri = '0, yi = '0, po, ro, yo;
	logic [11:0] dps;
	logic [7:0] lp1, lp2;
	logic [3:0] hpsel;
	int fails = 0, comparisons = 0;
	always #50 clk = ~clk;
	grf_top dut_u (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .ACCEL_ACTIVE_I(accel),
		.GYRO_POWER_DOWN_O(pd), .GYRO_RATE_SEL_O(rate), .GYRO_RATE_DHZ_O(dhz),
		.COMMON_RATE_SEL_O(crate), .COMMON_RATE_VALID_O(cvalid), .GYRO_RANGE_SEL_O(range),
		.GYRO_RANGE_DPS_O(dps), .GYRO_BW_SEL_O(bw), .FIRST_LOWPASS_HZ_O(lp1),
		.SECOND_LOWPASS_HZ_O(lp2), .SECOND_LOWPASS_ON_O(lp2on), .GYRO_LOW_POWER_O(lowp),
		.HIGHPASS_ON_O(hpon), .HIGHPASS_CUTOFF_SEL_O(hpsel), .HIGHPASS_CUTOFF_MHZ_O(hpmhz),
		.INT_PATH_SEL_O(ipath), .OUT_PATH_SEL_O(opath), .SAMPLE_VALID_I(sv),
		.PITCH_RATE_I(pi), .ROLL_RATE_I(ri), .YAW_RATE_I(yi), .SAMPLE_VALID_O(svo),
		.PITCH_RATE_O(po), .ROLL_RATE_O(ro), .YAW_RATE_O(yo));
	// wide enough for three packed axes and the error bit beside read data
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h0000_00, d};
		@(posedge clk);
		pen <= 1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 0;
		pen <= 0;
		// register outputs land at the access edge, lookup outputs one edge later
		repeat (3) @(posedge clk);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		apb(0, a, 8'h00);
		chk(rd_v, {24'h0000_00, e});
		chk(err_v, 0);
	endtask
	task automatic t_reset();
		rchk(A_RR, 8'h00);
		rchk(A_PS, 8'h00);
		rchk(A_FI, 8'h00);
		rchk(A_SM, 8'h00);
		chk({pd, dps, svo}, {1'b1, 12'h0F5, 1'b0});
		$display("test reset done");
	endtask
	task automatic t_range();
		logic [11:0] tab [4];
		tab = '{12'h0F5, 12'h1F4, 12'h000, 12'h7D0};
		for (int c = 0; c < 4; c += (c == 1) ? 2 : 1) begin
			apb(1, A_RR, 8'(c << 3));
			chk({range, dps}, {2'(c), tab[c]});
		end
		// unavailable range with a fresh rate and the reserved bit set
		apb(1, A_RR, 8'h34);
		rchk(A_RR, 8'h38);
		$display("test range done");
	endtask
	task automatic t_rate();
		logic [15:0] dtab [7];
		logic [7:0] ltab [7];
		dtab = '{16'h0000, 16'h0095, 16'h0253, 16'h04A6, 16'h094C, 16'h1298, 16'h2530};
		ltab = '{8'h00, 8'h05, 8'h13, 8'h26, 8'h4C, 8'h64, 8'h64};
		accel <= 1;
		for (int r = 0; r < 7; r++) begin
			apb(1, A_RR, {3'(r), 5'h00});
			chk({pd, rate, dhz}, {r == 0, 3'(r), dtab[r]});
			chk({cvalid, crate}, {r != 0, 3'(r)});
			if (r != 0) chk(lp1, ltab[r]);
		end
		accel <= 0;
		apb(1, A_RR, 8'hE0);
		chk({rate, cvalid, crate}, {3'b110, 1'b0, 3'b000});
		$display("test rate done");
	endtask
	task automatic lp2c(input logic [2:0] r, input logic [1:0] b, input logic [8:0] e);
		apb(1, A_RR, {r, 3'b000, b});
		chk(bw, b);
		if (r == 3'b001) chk(lp2on, 0);
		else chk({lp2on, lp2}, e);
	endtask
	task automatic t_lp2();
		lp2c(3'b001, 2'b11, 9'h000);
		lp2c(3'b010, 2'b00, 9'h110);
		lp2c(3'b010, 2'b11, 9'h110);
		lp2c(3'b011, 2'b00, 9'h10E);
		lp2c(3'b011, 2'b01, 9'h11F);
		lp2c(3'b100, 2'b11, 9'h14E);
		lp2c(3'b101, 2'b10, 9'h139);
		lp2c(3'b110, 2'b11, 9'h164);
		$display("test second lowpass done");
	endtask
	task automatic t_filter();
		apb(1, A_FI, 8'hFF);
		rchk(A_FI, 8'hCF);
		chk({lowp, hpon, hpsel, hpmhz}, {2'b11, 4'hF, 16'h0000});
		apb(1, A_FI, 8'h40);
		chk({lowp, hpon, hpmhz}, {2'b01, 16'hDEA8});
		apb(1, A_FI, 8'h09);
		chk({hpon, hpmhz}, {1'b0, 16'h0064});
		apb(1, A_FI, 8'h40);
		apb(1, A_RR, 8'h20);
		chk(hpmhz, 16'h03E8);
		apb(1, A_PS, 8'hF6);
		rchk(A_PS, 8'h06);
		chk({ipath, opath}, 4'b0110);
		$display("test filter and path done");
	endtask
	task automatic smp(input logic [15:0] p, r, y, input logic ok, input logic [47:0] e);
		@(posedge clk);
		sv <= 1;
		pi <= p;
		ri <= r;
		yi <= y;
		@(posedge clk);
		sv <= 0;
		#1 chk(svo, ok);
		if (ok) chk({po, ro, yo}, e);
		@(posedge clk);
		#1 chk(svo, 0);
	endtask
	task automatic t_sample();
		apb(1, A_SM, 8'h00);
		smp(16'h0010, 16'h0020, 16'h8000, 1, 48'h0010_0020_8000);
		apb(1, A_SM, 8'hF8 | {5'h00, ORIENT_YXZ});
		rchk(A_SM, 8'h3A);
		smp(16'h0010, 16'h0020, 16'h8000, 1, 48'hFFE0_FFF0_7FFF);
		apb(1, A_RR, 8'h00);
		smp(16'h0001, 16'h0002, 16'h0003, 0, 48'h0);
		apb(0, 12'h050, 8'h00);
		chk({err_v, rd_v}, {1'b1, 32'h0000_0000});
		apb(0, 12'h041, 8'h00);
		chk(err_v, 1);
		// status in power-down with the accelerometer idle: only bit 0 set
		rchk({IDX_STATUS, 2'b00}, 8'h01);
		// mid-run reset must bring the settings back to their defaults
		rst_n <= 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		rchk(A_SM, 8'h00);
		rchk(A_PS, 8'h00);
		$display("test samples and errors done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		t_reset();
		t_range();
		t_rate();
		t_lp2();
		t_filter();
		t_sample();
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		summarize();
	end
endmodule
`default_nettype wire
